// ### core/mcu_ctrl.v
// Metering control upper fields: register bank and the logic it steers
// Behaviour
// - Edge 0 falling, 1 rising crossing
// - Edge 2 both directions, 3 off
// - Upload enable sends accumulated data unpolled on each low-speed tick that finds the upload serialiser idle
// - Upload pin selectable among P0 to P6
// - Baud bit clear: UART last baud, SPI 4800
// - Baud bit set: UART double, SPI 9600
// - Low-speed accumulator enable, 50 Hz rate
// - Pulse out b invert bit flips polarity
// - Pulse out b driven only when enabled
// - Pulse out b source accumulator 1 or 2
// - Pulse out a invert bit flips polarity
// - Crossing source current A or B
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "mcu_defines.vh"

module mcu_ctrl #(
  parameter integer LS_CYCLES  = `MCU_LS_CYCLES,
  parameter integer SPI_CYCLES = `MCU_SPI_BIT_CYCLES,
  parameter integer NPINS      = 7
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        cur_a_sign,
  input  wire        cur_b_sign,
  input  wire        accum1_pulse,
  input  wire        accum2_pulse,
  input  wire        pulse_a_raw,
  input  wire        link_is_spi,
  input  wire [15:0] last_uart_bit_cycles,
  output reg         zero_cross,
  output reg         low_speed_tick,
  output reg  [31:0] low_speed_count,
  output reg         pulse_out_a,
  output reg         pulse_out_b,
  output reg         pulse_out_b_oe,
  output reg  [6:0]  upload_pins
);

  // --------------------------------------------------------------------
  // Input synchronisers (pins from outside the clock domain)
  // --------------------------------------------------------------------
  reg [1:0] sync_a;
  reg [1:0] sync_b;
  reg [1:0] sync_p1;
  reg [1:0] sync_p2;
  reg [1:0] sync_pa;
  reg       prev_sign;
  reg       prev_p1;
  reg       prev_p2;

  always @(posedge clk) begin
    if (srst) begin
      sync_a  <= 2'h0;
      sync_b  <= 2'h0;
      sync_p1 <= 2'h0;
      sync_p2 <= 2'h0;
      sync_pa <= 2'h0;
    end else if (ce) begin
      sync_a  <= {sync_a[0], cur_a_sign};
      sync_b  <= {sync_b[0], cur_b_sign};
      sync_p1 <= {sync_p1[0], accum1_pulse};
      sync_p2 <= {sync_p2[0], accum2_pulse};
      sync_pa <= {sync_pa[0], pulse_a_raw};
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [31:0] metering_control_second;
  reg [2:0]  status;
  reg [2:0]  mask;
  reg [31:0] upload_data;
  reg [2:0]  pin_configuration_setting;

  wire [1:0] edge_mode              = metering_control_second[
                                        `MCU_F_EDGE_HI:`MCU_F_EDGE_LO];
  wire       crossing_source_select = metering_control_second[`MCU_F_XSRC];
  wire       upload_baud_double     = metering_control_second[`MCU_F_BAUD2X];
  wire       upload_enable          = metering_control_second[`MCU_F_UPEN];
  wire       low_speed_accum_enable = metering_control_second[`MCU_F_LSEN];
  wire       pulse_out_b_invert     = metering_control_second[`MCU_F_B_INV];
  wire       pulse_out_b_enable     = metering_control_second[`MCU_F_B_EN];
  wire       pulse_out_b_source     = metering_control_second[`MCU_F_B_SRC];
  wire       pulse_out_a_invert     = metering_control_second[`MCU_F_A_INV];

  wire       wr_en   = psel & penable & pwrite & ~pready;
  wire       rd_en   = psel & penable & ~pwrite & ~pready;
  wire       addr_ok = (paddr == `MCU_ADDR_CTRL2) |
                       (paddr == `MCU_ADDR_STATUS) |
                       (paddr == `MCU_ADDR_MASK) |
                       (paddr == `MCU_ADDR_UPLOAD) |
                       (paddr == `MCU_ADDR_PINSEL);

  // --------------------------------------------------------------------
  // Zero-crossing detection
  // --------------------------------------------------------------------
  wire cur_sign = crossing_source_select ? sync_b[1] : sync_a[1];
  wire fall     = prev_sign & ~cur_sign;
  wire rise     = ~prev_sign & cur_sign;
  reg  next_zero_cross;

  // Edge mode picks which transitions count
  always @* begin
    case (edge_mode)
      `MCU_EDGE_FALL: next_zero_cross = fall;
      `MCU_EDGE_RISE: next_zero_cross = rise;
      `MCU_EDGE_BOTH: next_zero_cross = fall | rise;
      `MCU_EDGE_OFF:  next_zero_cross = 1'b0;
      default:        next_zero_cross = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Low-speed accumulator: 50 Hz tick and a running count of the ticks
  // --------------------------------------------------------------------
  reg [31:0] ls_div;
  wire       ls_wrap = (ls_div == LS_CYCLES - 1);

  // --------------------------------------------------------------------
  // Upload serialiser state machine
  // --------------------------------------------------------------------
  localparam [1:0] UP_IDLE  = 2'h0;
  localparam [1:0] UP_SHIFT = 2'h1;
  localparam [1:0] UP_GAP   = 2'h2;

  reg [1:0]  up_state;
  reg [9:0]  up_frame;
  reg [3:0]  up_bits;
  reg [16:0] up_cnt;
  reg        up_line;
  reg [1:0]  up_byte;
  reg [31:0] up_latch;

  // Bit time: SPI fixed 4800/9600, UART reuses last baud or doubles it
  wire [16:0] base_cycles = link_is_spi ? SPI_CYCLES[16:0]
                                        : {1'b0, last_uart_bit_cycles};
  wire [16:0] bit_cycles  = upload_baud_double ? {1'b0, base_cycles[16:1]}
                                               : base_cycles;
  wire [7:0]  up_octet    = up_latch[8*up_byte +: 8];

  // --------------------------------------------------------------------
  // Main sequential process
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      metering_control_second   <= `MCU_CTRL_RESET;
      status                    <= 3'h0;
      mask                      <= 3'h0;
      upload_data               <= 32'h00000000;
      pin_configuration_setting <= 3'h0;
      prdata                    <= 32'h00000000;
      pready                    <= 1'b0;
      pslverr                   <= 1'b0;
      irq                       <= 1'b0;
      prev_sign                 <= 1'b0;
      prev_p1                   <= 1'b0;
      prev_p2                   <= 1'b0;
      zero_cross                <= 1'b0;
      ls_div                    <= 32'h00000000;
      low_speed_tick            <= 1'b0;
      low_speed_count           <= 32'h00000000;
      pulse_out_a               <= 1'b0;
      pulse_out_b               <= 1'b0;
      pulse_out_b_oe            <= 1'b0;
      up_state                  <= UP_IDLE;
      up_frame                  <= 10'h3ff;
      up_bits                   <= 4'h0;
      up_cnt                    <= 17'h00000;
      up_line                   <= 1'b1;
      up_byte                   <= 2'h0;
      up_latch                  <= 32'h00000000;
      upload_pins               <= 7'h7f;
    end else if (ce) begin
      prev_sign  <= cur_sign;
      prev_p1    <= sync_p1[1];
      prev_p2    <= sync_p2[1];
      zero_cross <= next_zero_cross;

      // APB slave: one wait state, pready one cycle
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (wr_en) begin
        case (paddr)
          // Only documented bits are writable; bit 11 is held at 0
          `MCU_ADDR_CTRL2:  metering_control_second <=
                              pwdata & `MCU_CTRL_MASK &
                              ~(32'h1 << `MCU_F_RSVD);
          `MCU_ADDR_MASK:   mask <= pwdata[2:0];
          `MCU_ADDR_UPLOAD: upload_data <= pwdata;
          `MCU_ADDR_PINSEL: pin_configuration_setting <= pwdata[2:0];
          default: ;
        endcase
      end
      if (rd_en) begin
        case (paddr)
          `MCU_ADDR_CTRL2:  prdata <= metering_control_second;
          `MCU_ADDR_STATUS: prdata <= {29'h0, status};
          `MCU_ADDR_MASK:   prdata <= {29'h0, mask};
          `MCU_ADDR_UPLOAD: prdata <= upload_data;
          `MCU_ADDR_PINSEL: prdata <= {29'h0, pin_configuration_setting};
          default:          prdata <= 32'h00000000;
        endcase
      end

      // Sticky status: bit0 crossing, bit1 tick, bit2 upload done.
      // Read clears, but an event in the same cycle survives.
      status <= ((rd_en && paddr == `MCU_ADDR_STATUS) ? 3'h0 : status) |
                {up_state == UP_GAP && up_byte == 2'h0,
                 ls_wrap & low_speed_accum_enable,
                 next_zero_cross};
      irq <= |(status & mask);

      // Low-speed accumulator runs only while enabled
      low_speed_tick <= 1'b0;
      if (low_speed_accum_enable) begin
        ls_div <= ls_wrap ? 32'h0 : ls_div + 32'h1;
        if (ls_wrap) begin
          low_speed_tick  <= 1'b1;
          low_speed_count <= low_speed_count + 32'h1;
        end
      end else begin
        ls_div <= 32'h0;
      end

      // Pulse outputs
      pulse_out_a <= sync_pa[1] ^ pulse_out_a_invert;
      pulse_out_b <= pulse_out_b_enable &
                     ((pulse_out_b_source ? sync_p2[1] : sync_p1[1]) ^
                      pulse_out_b_invert);
      pulse_out_b_oe <= pulse_out_b_enable;

      // Upload: 8N1 frames of the four data bytes, LSB first
      case (up_state)
        UP_IDLE: begin
          up_line <= 1'b1;
          if (upload_enable && ls_wrap) begin
            up_latch <= upload_data;
            up_byte  <= 2'h0;
            up_frame <= {1'b1, upload_data[7:0], 1'b0};
            up_bits  <= 4'h0;
            // Count runs to zero inclusive, so load one less than a bit
            up_cnt   <= bit_cycles - 17'h1;
            up_state <= UP_SHIFT;
          end
        end
        UP_SHIFT: begin
          up_line <= up_frame[0];
          if (up_cnt == 17'h0) begin
            up_cnt   <= bit_cycles - 17'h1;
            up_frame <= {1'b1, up_frame[9:1]};
            up_bits  <= up_bits + 4'h1;
            if (up_bits == 4'h9) begin
              up_byte  <= up_byte + 2'h1;
              up_state <= UP_GAP;
            end
          end else begin
            up_cnt <= up_cnt - 17'h1;
          end
        end
        UP_GAP: begin
          up_line <= 1'b1;
          if (up_byte == 2'h0 || !upload_enable) begin
            up_byte  <= 2'h0;
            up_cnt   <= 17'h0;
            up_state <= UP_IDLE;
          end else begin
            up_frame <= {1'b1, up_octet, 1'b0};
            up_bits  <= 4'h0;
            up_cnt   <= bit_cycles - 17'h1;
            up_state <= UP_SHIFT;
          end
        end
        default: up_state <= UP_IDLE;
      endcase

      // Route the serial line to the chosen pin, others idle high
      upload_pins <= 7'h7f;
      if (pin_configuration_setting < NPINS[2:0])
        upload_pins[pin_configuration_setting] <= up_line;
    end
  end

endmodule
`default_nettype wire

// ### core/mcu_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef MCU_DEFINES_VH
`define MCU_DEFINES_VH

// ----------------------------------------------------------------------
// Register map (byte addresses; index 0x03 times four)
// ----------------------------------------------------------------------
`define MCU_IDX_CTRL2        8'h03
`define MCU_ADDR_CTRL2       8'h0c
`define MCU_ADDR_STATUS      8'h40
`define MCU_ADDR_MASK        8'h44
`define MCU_ADDR_UPLOAD      8'h48
`define MCU_ADDR_PINSEL      8'h4c

// ----------------------------------------------------------------------
// Field positions inside metering_control_second
// ----------------------------------------------------------------------
`define MCU_F_XSRC           20
`define MCU_F_EDGE_HI        19
`define MCU_F_EDGE_LO        18
`define MCU_F_BAUD2X         17
`define MCU_F_UPEN           16
`define MCU_F_LSEN           15
`define MCU_F_B_INV          14
`define MCU_F_B_EN           13
`define MCU_F_B_SRC          12
`define MCU_F_RSVD           11
`define MCU_F_A_INV          10
`define MCU_CTRL_MASK        32'h001ff400
`define MCU_CTRL_RESET       32'h00000000

// ----------------------------------------------------------------------
// Edge modes
// ----------------------------------------------------------------------
`define MCU_EDGE_FALL        2'h0
`define MCU_EDGE_RISE        2'h1
`define MCU_EDGE_BOTH        2'h2
`define MCU_EDGE_OFF         2'h3

// ----------------------------------------------------------------------
// Timing: 25 MHz clock, 50 Hz tick, SPI upload baud 4800/9600
// ----------------------------------------------------------------------
`define MCU_CLK_HZ           25000000
`define MCU_LS_HZ            50
`define MCU_LS_CYCLES        (`MCU_CLK_HZ / `MCU_LS_HZ)
`define MCU_SPI_BAUD         4800
`define MCU_SPI_BIT_CYCLES   (`MCU_CLK_HZ / `MCU_SPI_BAUD)

`endif

// ### test/mcu_ctrl_sva.sv
// Assertion checker for the metering control upper fields
`timescale 1ns/1ps
`default_nettype none
`include "mcu_defines.vh"
module mcu_ctrl_sva (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cur_a_sign,
  input wire logic        cur_b_sign,
  input wire logic        accum1_pulse,
  input wire logic        accum2_pulse,
  input wire logic        pulse_a_raw,
  input wire logic        zero_cross,
  input wire logic        low_speed_tick,
  input wire logic [31:0] low_speed_count,
  input wire logic        pulse_out_a,
  input wire logic        pulse_out_b,
  input wire logic        pulse_out_b_oe,
  input wire logic [6:0]  upload_pins
);
  logic [31:0] sh;
  logic [3:0]  ws;
  logic [3:0]  qs;
  logic        sel;
  logic        wr;
  assign sel = sh[20] ? cur_b_sign : cur_a_sign;
  assign wr = psel & penable & pready & pwrite & (paddr == `MCU_ADDR_CTRL2);
  // -------------------------------------------------------------------
  // Shadow control word and settling counters
  // -------------------------------------------------------------------
  // Counters keep checks clear of control writes and of the input synchroniser latency
  always_ff @(posedge clk) begin
    if (srst) begin
      sh <= 32'h0;
      ws <= 4'h0;
      qs <= 4'h0;
    end else begin
      if (wr) sh <= pwdata & `MCU_CTRL_MASK;
      ws <= wr ? 4'h0 : ws + {3'h0, ws != 4'hf};
      if (wr || $changed(pulse_a_raw) || $changed(accum1_pulse) ||
          $changed(accum2_pulse)) qs <= 4'h0;
      else qs <= qs + {3'h0, qs != 4'hf};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // -------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_A_POL: assert property (qs > 4'h7 |-> pulse_out_a == (pulse_a_raw ^ sh[10]))
    else $error("pulse_out_a polarity wrong");
  AST_B_OUT: assert property (qs > 4'h7 |-> pulse_out_b == (sh[13] &
    ((sh[12] ? accum2_pulse : accum1_pulse) ^ sh[14])))
    else $error("pulse_out_b value wrong");
  AST_B_OE: assert property (ws > 4'h3 |-> pulse_out_b_oe == sh[13])
    else $error("pulse_out_b_oe does not follow enable");
  AST_ZC_CAUSE: assert property (zero_cross && ws > 4'h7 |->
    sh[19:18] == 2'h2 || sh[19:18] == {1'b0, sel})
    else $error("zero_cross on wrong edge or source");
  AST_ZC_SEEN: assert property ($changed(sel) && ws > 4'h7 &&
    (sh[19:18] == 2'h2 || sh[19:18] == {1'b0, sel}) |-> ##[1:8] zero_cross)
    else $error("zero_cross missing");
  AST_RESET: assert property ($fell(srst) |-> !pulse_out_b_oe && !pulse_out_b
    && !low_speed_tick && low_speed_count == 32'h0 && upload_pins == 7'h7f)
    else $error("outputs not at reset values");
  AST_TICK_PULSE: assert property (low_speed_tick |=> !low_speed_tick)
    else $error("tick longer than one cycle");
  AST_CNT_STEP: assert property ($changed(low_speed_count) && ws > 4'h1 |->
    sh[15] && low_speed_count == $past(low_speed_count) + 32'h1)
    else $error("tick count stepped wrongly");
  AST_UP_EN: assert property ($fell(&upload_pins) && ws > 4'h1 |-> sh[16])
    else $error("upload without enable");
  COV_ZC: cover property (zero_cross);
  COV_UP: cover property ($fell(&upload_pins));
  COV_ERR: cover property (pslverr);
endmodule
bind mcu_ctrl mcu_ctrl_sva u_sva (.*);
`default_nettype wire

// ### test/mcu_front.sv
// Front-end model: current signs, accumulator pulses, raw first pulse
`timescale 1ns/1ps
`default_nettype none
module mcu_front (
  input  wire logic       clk,
  input  wire logic [4:0] want,
  output var  logic [4:0] lines
);
  // Lines follow the request one clock late, unrelated to APB traffic
  initial lines = 5'h0;
  always @(posedge clk) lines <= want;
endmodule
`default_nettype wire

// ### test/metering_ctrl_upper_fields_bench.sv
// Testbench for the metering control upper fields
`timescale 1ns/1ps
`default_nettype none
`include "mcu_defines.vh"
module metering_ctrl_upper_fields_bench;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, irq, zc, tick, pa, pb, oe, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, cnt, c, d, x;
  logic [31:0] seed = 32'd45490;
  logic [6:0]  up;
  logic [4:0]  want = 5'h0, fl;
  logic [1:0]  p;
  int          errors = 0, total_checks = 0, i, j, n, zn, tn;
  always #20 clk = ~clk;
  mcu_front u_front (.clk(clk), .want(want), .lines(fl));
  mcu_ctrl #(.LS_CYCLES(50), .SPI_CYCLES(20)) dut (.clk(clk), .srst(srst),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .cur_a_sign(fl[0]), .cur_b_sign(fl[1]),
    .accum1_pulse(fl[2]), .accum2_pulse(fl[3]), .pulse_a_raw(fl[4]),
    .link_is_spi(1'b1), .last_uart_bit_cycles(16'h0010), .zero_cross(zc),
    .low_speed_tick(tick), .low_speed_count(cnt), .pulse_out_a(pa),
    .pulse_out_b(pb), .pulse_out_b_oe(oe), .upload_pins(up));
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo();
    errors++;
    $display("Error at %0t: wait ran out", $time);
    final_report();
  endtask
  // APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Values read right after the edge are those sampled at that edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts crossings and ticks over a span of cycles
  task automatic span(input int k);
    zn = 0;
    tn = 0;
    repeat (k) begin
      @(negedge clk);
      zn += zc;
      tn += tick;
    end
  endtask
  task automatic setin(input logic [4:0] v);
    @(posedge clk);
    want <= v;
    span(12);
  endtask
  function automatic logic [1:0] pexp(input logic [31:0] k, input logic [4:0] v);
    return {k[13] & ((k[12] ? v[3] : v[2]) ^ k[14]), v[4] ^ k[10]};
  endfunction
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    chk({oe, pb, tick, up}, 10'h07f);
    apb(`MCU_ADDR_CTRL2, 1'b0, 32'h0);
    chk(rd, `MCU_CTRL_RESET);
    for (i = 0; i < 6; i++) begin
      d = rnd() & ~32'h00018800;
      apb(`MCU_ADDR_CTRL2, 1'b1, d);
      apb(`MCU_ADDR_CTRL2, 1'b0, 32'h0);
      chk(rd, d & `MCU_CTRL_MASK);
    end
    apb(8'h80, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("Test registers done");
    for (i = 0; i < 12; i++) begin
      c = rnd() & 32'h001e7400;
      apb(`MCU_ADDR_CTRL2, 1'b1, c);
      d = rnd();
      setin(d[4:0]);
      p = pexp(c, d[4:0]);
      chk({pb, oe}, {p[1], c[13]});
      chk(pa, p[0]);
    end
    $display("Test pulse outputs done");
    for (i = 0; i < 8; i++) begin
      apb(`MCU_ADDR_CTRL2, 1'b1, {11'h0, i[2], i[1:0], 18'h0});
      for (j = 0; j < 3; j++) begin
        d = {27'h0, want ^ (j < 2 ? 5'h1 << i[2] : 5'h2 >> i[2])};
        setin(d[4:0]);
        x = (j < 2 && (i[1:0] == 2) || i[1:0] == {1'b0, d[i[2]]}) ? 1 : 0;
        chk(zn, j < 2 ? x : 0);
      end
    end
    $display("Test zero crossing done");
    apb(`MCU_ADDR_MASK, 1'b1, 32'h2);
    apb(`MCU_ADDR_CTRL2, 1'b1, 32'h8000);
    apb(`MCU_ADDR_STATUS, 1'b0, 32'h0);
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(negedge clk);
    if (irq !== 1'b1) tmo();
    apb(`MCU_ADDR_STATUS, 1'b0, 32'h0);
    span(2);
    chk({rd[1], irq}, 2'h2);
    span(100);
    chk(tn, 2);
    apb(`MCU_ADDR_MASK, 1'b1, 32'h0);
    span(100);
    chk({tn[1:0], irq}, 3'h4);
    apb(`MCU_ADDR_CTRL2, 1'b1, 32'h0);
    x = cnt;
    span(120);
    chk(tn, 0);
    chk(cnt, x);
    $display("Test low speed and interrupt done");
    apb(`MCU_ADDR_UPLOAD, 1'b1, 32'hffffffff);
    for (i = 0; i < 2; i++) begin
      j = rnd() % 7;
      apb(`MCU_ADDR_PINSEL, 1'b1, j);
      apb(`MCU_ADDR_CTRL2, 1'b1, 32'h18000 | (i << 17));
      for (n = 0; n < 900 && up[j] !== 1'b0; n++) @(negedge clk);
      if (up[j] !== 1'b0) tmo();
      chk(up | (7'h1 << j), 7'h7f);
      for (n = 0; n < 100 && up[j] === 1'b0; n++) @(negedge clk);
      chk(n, 20 >> i);
    end
    $display("Test upload done");
    final_report();
  end
endmodule
`default_nettype wire
